/* hw/pwsu_pkg.sv */
// constants and types for the pwm synchronization and update control block
package pwsu_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_SYNC_CTRL = 8'h1b;
  localparam logic [7:0] ADDR_PRESET = 8'h1c;
  // block's own registers
  localparam logic [7:0] ADDR_MODE = 8'h1d;
  localparam logic [7:0] ADDR_MASK = 8'h1e;
  localparam logic [7:0] ADDR_STATUS = 8'h1f;
  localparam logic [7:0] ADDR_PERIOD = 8'h20;
  localparam logic [7:0] ADDR_START = 8'h21;
  localparam logic [7:0] ADDR_MATCH = 8'h22;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int BIT_SOFT = 7;
  localparam int BIT_HW2 = 6;
  localparam int BIT_HW1 = 5;
  localparam int BIT_HW0 = 4;
  localparam int BIT_MASKSEL = 3;
  localparam int BIT_RELOAD = 2;
  localparam int BIT_MAX = 1;
  localparam int BIT_MIN = 0;
  localparam int BIT_TYPEMODE = 3;
  localparam int BIT_PRESET_STB = 1;
  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] RST_SYNC_CTRL = 8'h00;
  localparam logic [7:0] RST_PRESET = 8'h00;
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [7:0] RST_PERIOD = 8'hff;
  localparam logic [7:0] RST_START = 8'h00;
  localparam logic [7:0] RST_MATCH = 8'h00;
  localparam int NUM_TRIG = 3;
  localparam int NUM_CH = 8;

  // pending boundary load state
  typedef enum logic [1:0] {
    PWSU_IDLE = 2'b01,
    PWSU_ARMED = 2'b10
  } pwsu_load_e;
endpackage : pwsu_pkg

/* hw/pwsu_trig_if.sv */
// trigger carrier between the edge detector and the control logic
`timescale 1ns/1ps
interface pwsu_trig_if;
  logic [2:0] rawTrig;
  logic [2:0] trigRise;
  modport det (input rawTrig, output trigRise);
  modport ctl (output rawTrig, input trigRise);
endinterface : pwsu_trig_if

/* hw/pwsu_edge_detect.sv */
// synchronising rising edge detector for the hardware triggers
`timescale 1ns/1ps
module pwsu_edge_detect
  import pwsu_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic sys_rst, // async reset, active high
  input wire logic clkEn, // freezes state when low
  pwsu_trig_if.det trig // raw in, rise pulses out
);
  logic [2:0] meta_reg;
  logic [2:0] sync_reg;
  logic [2:0] prev_reg;

  // two flops before any logic looks at the pins
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_reg <= 3'h0;
      sync_reg <= 3'h0;
    end else if (clkEn) begin
      meta_reg <= trig.rawTrig;
      sync_reg <= meta_reg;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_reg <= 3'h0;
    end else if (clkEn) begin
      prev_reg <= sync_reg;
    end
  end

  assign trig.trigRise = clkEn ? (sync_reg & ~prev_reg) : 3'h0;
endmodule : pwsu_edge_detect

/* hw/pwsu_sync_ctrl.sv */
// pwm synchronization and buffered update control
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
module pwsu_sync_ctrl
  import pwsu_pkg::*;
(
  input wire logic clk, // system clock, 200 mhz
  input wire logic sys_rst, // async reset, active high
  input wire logic clkEn, // freezes all state when low
  input wire logic [7:0] regAddr, // register byte address
  input wire logic [7:0] regWdata, // write data
  input wire logic regWr, // write strobe
  input wire logic regRd, // read strobe
  output logic [7:0] regRdata, // read data, cycle after strobe
  input wire logic [2:0] hwTrig, // hardware trigger pins
  input wire logic [7:0] counterVal, // timer counter value
  output logic counterReload, // pulse: load counter start value
  output logic [7:0] periodValue, // active period
  output logic [7:0] counterStartValue, // active start value
  output logic [7:0] channelMatchValue, // active match value
  output logic [7:0] channelMaskReg, // active channel masks
  output logic [7:0] chanForce, // 1: channel held inactive
  output logic presetLoad, // pulse: force outputs to preset
  output logic [7:0] presetLevel // preset levels
);
  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  logic [7:0] syncCtrl_reg;
  logic [7:0] preset_reg;
  logic typeMode_reg;
  logic [7:0] maskBuf_reg;
  logic [7:0] mask_reg;
  logic [7:0] periodBuf_reg;
  logic [7:0] startBuf_reg;
  logic [7:0] matchBuf_reg;
  logic [7:0] period_reg;
  logic [7:0] start_reg;
  logic [7:0] match_reg;
  logic softPend_reg;
  logic presetLoad_reg;
  logic reload_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdataNext;
  logic syncSeen_reg;
  pwsu_load_e load_reg;
  pwsu_load_e loadNext;

  // ------------------------------------------------------------
  // trigger detection
  // ------------------------------------------------------------
  pwsu_trig_if trigBus ();
  assign trigBus.rawTrig = hwTrig;

  pwsu_edge_detect uEdge (
    .clk(clk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .trig(trigBus)
  );

  function automatic logic wr_hit(input logic [7:0] a);
    wr_hit = clkEn && regWr && (regAddr == a);
  endfunction : wr_hit

  logic softFire;
  logic hwFire;
  logic valueSync;
  logic maskCntSync;
  logic atMax;
  logic atMin;

  // software trigger taken from the written one
  assign softFire = softPend_reg & syncCtrl_reg[BIT_SOFT];
  assign hwFire = |(trigBus.trigRise & syncCtrl_reg[BIT_HW2:BIT_HW0]);
  // mode decides which kind serves which
  // event is or of selected sources
  assign valueSync = softFire | (hwFire & ~typeMode_reg);
  assign maskCntSync = hwFire | (softFire & ~typeMode_reg);

  assign atMax = (counterVal == period_reg);
  assign atMin = (counterVal == start_reg);

  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  // control and preset decode
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      syncCtrl_reg <= RST_SYNC_CTRL;
    end else if (wr_hit(ADDR_SYNC_CTRL)) begin
      syncCtrl_reg <= regWdata;
    end else if (clkEn && softFire) begin
      // software select drops once its trigger is used
      syncCtrl_reg[BIT_SOFT] <= 1'b0;
    end
  end

  // a written one arms the software trigger
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      softPend_reg <= 1'b0;
    end else if (clkEn) begin
      softPend_reg <= wr_hit(ADDR_SYNC_CTRL) && regWdata[BIT_SOFT];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      preset_reg <= RST_PRESET;
    end else if (wr_hit(ADDR_PRESET)) begin
      preset_reg <= regWdata;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      typeMode_reg <= 1'b0;
    end else if (wr_hit(ADDR_MODE)) begin
      typeMode_reg <= regWdata[BIT_TYPEMODE];
    end
  end

  // strobe is a pulse, never stored
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      presetLoad_reg <= 1'b0;
    end else if (clkEn) begin
      presetLoad_reg <= wr_hit(ADDR_MODE) && regWdata[BIT_PRESET_STB];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      maskBuf_reg <= RST_MASK;
      periodBuf_reg <= RST_PERIOD;
      startBuf_reg <= RST_START;
      matchBuf_reg <= RST_MATCH;
    end else if (clkEn && regWr) begin
      if (regAddr == ADDR_MASK) begin
        maskBuf_reg <= regWdata;
      end
      if (regAddr == ADDR_PERIOD) begin
        periodBuf_reg <= regWdata;
      end
      if (regAddr == ADDR_START) begin
        startBuf_reg <= regWdata;
      end
      if (regAddr == ADDR_MATCH) begin
        matchBuf_reg <= regWdata;
      end
    end
  end

  // ------------------------------------------------------------
  // channel mask update
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mask_reg <= RST_MASK;
    end else if (clkEn) begin
      if (!syncCtrl_reg[BIT_MASKSEL]) begin
        mask_reg <= maskBuf_reg;
      end else if (maskCntSync) begin
        mask_reg <= maskBuf_reg;
      end
    end
  end

  // ------------------------------------------------------------
  // counter reload
  // ------------------------------------------------------------
  // reload pulse on selected trigger
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reload_reg <= 1'b0;
    end else if (clkEn) begin
      reload_reg <= maskCntSync & syncCtrl_reg[BIT_RELOAD];
    end
  end

  // ------------------------------------------------------------
  // boundary loads
  // ------------------------------------------------------------
  // without a boundary selected values load at the event itself
  always_comb begin
    loadNext = load_reg;
    case (load_reg)
      PWSU_IDLE: begin
        if (valueSync && (syncCtrl_reg[BIT_MAX] || syncCtrl_reg[BIT_MIN])) begin
          loadNext = PWSU_ARMED;
        end
      end
      PWSU_ARMED: begin
        if ((syncCtrl_reg[BIT_MAX] && atMax) ||
            (syncCtrl_reg[BIT_MIN] && atMin) ||
            !(syncCtrl_reg[BIT_MAX] || syncCtrl_reg[BIT_MIN])) begin
          loadNext = PWSU_IDLE;
        end
      end
      default: begin
        loadNext = PWSU_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      load_reg <= PWSU_IDLE;
    end else if (clkEn) begin
      load_reg <= loadNext;
    end
  end

  logic maxLoad;
  logic minLoad;
  logic directLoad;
  assign maxLoad = (load_reg == PWSU_ARMED) && syncCtrl_reg[BIT_MAX]
                   && atMax;
  assign minLoad = (load_reg == PWSU_ARMED) && syncCtrl_reg[BIT_MIN]
                   && atMin;
  assign directLoad = valueSync && !syncCtrl_reg[BIT_MAX]
                      && !syncCtrl_reg[BIT_MIN];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      period_reg <= RST_PERIOD;
      match_reg <= RST_MATCH;
    end else if (clkEn && (maxLoad || minLoad || directLoad)) begin
      period_reg <= periodBuf_reg;
      match_reg <= matchBuf_reg;
    end
  end

  // start value only on max or direct load
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      start_reg <= RST_START;
    end else if (clkEn && (maxLoad || directLoad)) begin
      start_reg <= startBuf_reg;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      syncSeen_reg <= 1'b0;
    end else if (clkEn && (valueSync || maskCntSync)) begin
      syncSeen_reg <= 1'b1;
    end else if (clkEn && regRd && regAddr == ADDR_STATUS) begin
      syncSeen_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // read back
  // ------------------------------------------------------------
  always_comb begin
    case (regAddr)
      ADDR_SYNC_CTRL: rdataNext = syncCtrl_reg;
      ADDR_PRESET: rdataNext = preset_reg;
      ADDR_MODE: rdataNext = {4'h0, typeMode_reg, 3'h0};
      ADDR_MASK: rdataNext = mask_reg;
      ADDR_STATUS: rdataNext = {6'h00, load_reg == PWSU_ARMED,
                                syncSeen_reg};
      ADDR_PERIOD: rdataNext = period_reg;
      ADDR_START: rdataNext = start_reg;
      ADDR_MATCH: rdataNext = match_reg;
      default: rdataNext = 8'h00;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_reg <= 8'h00;
    end else if (clkEn) begin
      rdata_reg <= regRd ? rdataNext : 8'h00;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign regRdata = rdata_reg;
  assign counterReload = reload_reg;
  assign periodValue = period_reg;
  assign counterStartValue = start_reg;
  assign channelMatchValue = match_reg;
  assign channelMaskReg = mask_reg;
  assign chanForce = mask_reg;
  assign presetLoad = presetLoad_reg;
  assign presetLevel = preset_reg;
endmodule : pwsu_sync_ctrl

/* dv/pwsu_sync_ctrl_chk.sv */
// assertion checker for the pwm sync control block
`timescale 1ns/1ps
module pwsu_sync_ctrl_chk
  import pwsu_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic sys_rst, // async reset
  input wire logic clkEn, // clock enable
  input wire logic [7:0] regAddr, // address
  input wire logic [7:0] regWdata, // write data
  input wire logic regWr, // write strobe
  input wire logic regRd, // read strobe
  input wire logic [7:0] regRdata, // read data
  input wire logic [2:0] hwTrig, // trigger pins
  input wire logic [7:0] counterVal, // counter
  input wire logic counterReload, // reload pulse
  input wire logic [7:0] periodValue, // period
  input wire logic [7:0] counterStartValue, // start
  input wire logic [7:0] channelMatchValue, // match
  input wire logic [7:0] channelMaskReg, // mask
  input wire logic [7:0] chanForce, // force
  input wire logic presetLoad, // preset pulse
  input wire logic [7:0] presetLevel // preset
);
  logic [7:0] ctrlQ;
  logic modeQ;
  logic wrEn;
  assign wrEn = regWr && clkEn;
  // shadow of control bits; soft bit never sticks
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) ctrlQ <= 8'h00;
    else if (wrEn && regAddr == ADDR_SYNC_CTRL) ctrlQ <= regWdata & 8'h7f;
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) modeQ <= 1'b0;
    else if (wrEn && regAddr == ADDR_MODE) modeQ <= regWdata[BIT_TYPEMODE];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_read_idle_zero: assert property (
    !$past(regRd) |-> regRdata == 8'h00) else $error("rdata not idle");
  a_preset_read_back: assert property (
    regRd && clkEn && regAddr == ADDR_PRESET |=> regRdata == $past(presetLevel))
    else $error("preset readback wrong");
  a_force_is_mask: assert property (
    chanForce == channelMaskReg) else $error("force differs from mask");
  a_preset_one_pulse: assert property (
    wrEn && regAddr == ADDR_MODE && regWdata[BIT_PRESET_STB]
    |-> ##[1:3] presetLoad ##1 !presetLoad) else $error("preset pulse bad");
  a_soft_reload_fires: assert property (
    wrEn && regAddr == ADDR_SYNC_CTRL && regWdata[7] && regWdata[2] && !modeQ
    |-> ##[1:4] counterReload) else $error("soft reload missing");
  a_hw_reload_fires: assert property (
    $rose(hwTrig[0]) && ctrlQ[4] && ctrlQ[2] |-> ##[2:5] counterReload)
    else $error("hw reload missing");
  a_mask_free_copy: assert property (
    wrEn && regAddr == ADDR_MASK && !ctrlQ[3]
    |-> ##2 channelMaskReg == $past(regWdata, 2)) else $error("mask not copied");
  a_max_load_at_top: assert property (
    $changed(periodValue) && $past(ctrlQ[1:0]) == 2'b10
    |-> $past(counterVal) == $past(periodValue)) else $error("max load early");
  a_min_load_at_start: assert property (
    $changed(periodValue) && $past(ctrlQ[1:0]) == 2'b01
    |-> $past(counterVal) == $past(counterStartValue))
    else $error("min load early");
  a_min_keeps_start: assert property (
    ctrlQ[1:0] == 2'b01 && $past(ctrlQ[1:0]) == 2'b01
    |-> $stable(counterStartValue)) else $error("start changed on min");
endmodule : pwsu_sync_ctrl_chk

bind pwsu_sync_ctrl pwsu_sync_ctrl_chk u_chk (.clk(clk), .sys_rst(sys_rst),
  .clkEn(clkEn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
  .regRd(regRd), .regRdata(regRdata), .hwTrig(hwTrig),
  .counterVal(counterVal), .counterReload(counterReload),
  .periodValue(periodValue), .counterStartValue(counterStartValue),
  .channelMatchValue(channelMatchValue), .channelMaskReg(channelMaskReg),
  .chanForce(chanForce), .presetLoad(presetLoad), .presetLevel(presetLevel));

/* dv/pwsu_trig_src.sv */
// trigger pin and counter model on the far side of the sync block
`timescale 1ns/1ps
module pwsu_trig_src (
  input wire logic clk, // system clock
  input wire logic sys_rst, // async reset
  input wire logic counterReload, // reload pulse
  input wire logic [7:0] periodValue, // wrap value
  input wire logic [7:0] counterStartValue, // start value
  output logic [2:0] hwTrig, // trigger pins
  output logic [7:0] counterVal // counter
);
  initial hwTrig = 3'h0;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) counterVal <= 8'h00;
    else if (counterReload || counterVal == periodValue)
      counterVal <= counterStartValue;
    else counterVal <= counterVal + 8'h01;
  end
  // held several clocks so the two-flop sampler cannot miss it
  task automatic pulse(input int i);
    @(posedge clk);
    hwTrig[i] <= 1'b1;
    repeat (4) @(posedge clk);
    hwTrig[i] <= 1'b0;
  endtask : pulse
endmodule : pwsu_trig_src

/* dv/tb_top.sv */
// testbench for the pwm sync control block
`timescale 1ns/1ps
module tb_top;
  import pwsu_pkg::*;
  logic clk, sys_rst, clkEn, regWr, regRd, counterReload, presetLoad;
  logic [7:0] regAddr, regWdata, regRdata, counterVal, periodValue;
  logic [7:0] counterStartValue, channelMatchValue, channelMaskReg;
  logic [7:0] chanForce, presetLevel, s;
  logic [2:0] hwTrig;
  int fails, num_checks;
  pwsu_sync_ctrl u_pwsu_sync_ctrl (.clk(clk), .sys_rst(sys_rst),
    .clkEn(clkEn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .hwTrig(hwTrig),
    .counterVal(counterVal), .counterReload(counterReload),
    .periodValue(periodValue), .counterStartValue(counterStartValue),
    .channelMatchValue(channelMatchValue), .channelMaskReg(channelMaskReg),
    .chanForce(chanForce), .presetLoad(presetLoad), .presetLevel(presetLevel));
  pwsu_trig_src u_pwsu_trig_src (.clk(clk), .sys_rst(sys_rst),
    .counterReload(counterReload), .periodValue(periodValue),
    .counterStartValue(counterStartValue), .hwTrig(hwTrig),
    .counterVal(counterVal));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ------------------------------------------------------------
  // bus and check helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    chk(regRdata, e);
  endtask : rd
  // s goes to 1 if the watched pulse shows within n cycles
  task automatic seen(input bit pre, input int n);
    s = 8'h00;
    repeat (n) begin
      @(posedge clk);
      #1;
      if ((pre ? presetLoad : counterReload) === 1'b1) s = 8'h01;
    end
  endtask : seen
  task automatic waitPer(input logic [7:0] v);
    repeat (600) begin
      @(posedge clk);
      #1;
      if (periodValue === v) break;
    end
    chk(periodValue, v);
  endtask : waitPer
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    rd(ADDR_SYNC_CTRL, 8'h00);
    rd(ADDR_PERIOD, 8'hff);
    rd(8'h30, 8'h00);
    wr(ADDR_SYNC_CTRL, 8'h84);
    rd(ADDR_SYNC_CTRL, 8'h04);
    rd(ADDR_STATUS, 8'h01);
    rd(ADDR_STATUS, 8'h00);
  endtask : t_regs
  task automatic t_preset();
    wr(ADDR_PRESET, 8'h5a);
    rd(ADDR_PRESET, 8'h5a);
    chk(presetLevel, 8'h5a);
    fork
      wr(ADDR_MODE, 8'h02);
      seen(1'b1, 6);
    join
    chk(s, 8'h01);
    rd(ADDR_MODE, 8'h00);
  endtask : t_preset
  task automatic t_mask();
    wr(ADDR_MASK, 8'h3c);
    repeat (2) @(posedge clk);
    #1;
    chk(channelMaskReg, 8'h3c);
    chk(chanForce, 8'h3c);
    wr(ADDR_SYNC_CTRL, 8'h08);
    wr(ADDR_MASK, 8'hc3);
    repeat (3) @(posedge clk);
    #1;
    chk(channelMaskReg, 8'h3c);
    fork
      wr(ADDR_SYNC_CTRL, 8'h88);
      seen(1'b0, 4);
    join
    chk(channelMaskReg, 8'hc3);
  endtask : t_mask
  task automatic t_hw();
    // hardware triggers never mixed with the soft one
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_MASK, 8'(i + 1));
      wr(ADDR_SYNC_CTRL, 8'h0c | (8'h10 << i));
      fork
        u_pwsu_trig_src.pulse(i);
        seen(1'b0, 8);
      join
      chk(s, 8'h01);
      chk(channelMaskReg, 8'(i + 1));
    end
    wr(ADDR_SYNC_CTRL, 8'h14);
    fork
      u_pwsu_trig_src.pulse(1);
      seen(1'b0, 8);
    join
    chk(s, 8'h00);
  endtask : t_hw
  task automatic t_bound();
    // boundary loads only with the soft trigger
    wr(ADDR_PERIOD, 8'h30);
    wr(ADDR_START, 8'h05);
    wr(ADDR_MATCH, 8'h10);
    wr(ADDR_SYNC_CTRL, 8'h82);
    waitPer(8'h30);
    chk(counterStartValue, 8'h05);
    chk(channelMatchValue, 8'h10);
    wr(ADDR_PERIOD, 8'h40);
    wr(ADDR_START, 8'h09);
    wr(ADDR_MATCH, 8'h22);
    wr(ADDR_SYNC_CTRL, 8'h81);
    waitPer(8'h40);
    chk(counterStartValue, 8'h05);
    chk(channelMatchValue, 8'h22);
  endtask : t_bound
  task automatic t_mode();
    wr(ADDR_MODE, 8'h08);
    wr(ADDR_PERIOD, 8'h44);
    fork
      wr(ADDR_SYNC_CTRL, 8'h84);
      seen(1'b0, 8);
    join
    chk(s, 8'h00);
    chk(periodValue, 8'h44);
    wr(ADDR_PERIOD, 8'h50);
    wr(ADDR_SYNC_CTRL, 8'h14);
    fork
      u_pwsu_trig_src.pulse(0);
      seen(1'b0, 8);
    join
    chk(s, 8'h01);
    chk(periodValue, 8'h44);
  endtask : t_mode
  task automatic summarize();
    if (fails == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  initial begin
    #50000;
    fails++;
    summarize();
  end
  initial begin
    fails = 0;
    num_checks = 0;
    sys_rst = 1'b1;
    clkEn = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs();
    t_preset();
    t_mask();
    t_hw();
    t_bound();
    t_mode();
    summarize();
  end
endmodule : tb_top
